// ### logic/ctffi_pkg.sv
// Purpose: Constants for the CAN time-stamp, filter and FIFO status block
// Assumes: 32-bit register port with byte addresses
// Notes:   Offsets are word aligned
package ctffi_pkg;
  localparam int NFIFO = 32;
  localparam int NFLT  = 16;
  // Register map
  localparam logic [9:0] OFS_TIMER     = 10'h000;
  localparam logic [9:0] OFS_FLT_BASE  = 10'h010;
  localparam logic [9:0] OFS_OVF_SUM   = 10'h020;
  localparam logic [9:0] OFS_FIFO_BASE = 10'h100;
  // Timer fields
  localparam int TS_LSB  = 16;
  localparam int DIV_LSB = 0;
  localparam logic [31:0] TIMER_RST = 32'h0000_0000;
  // Filter byte fields
  localparam int FLT_EN_BIT  = 7;
  localparam int FLT_MSK_LSB = 5;
  localparam int FLT_DST_LSB = 0;
  localparam logic [7:0] FLT_RST = 8'h00;
  // FIFO interrupt register fields
  localparam int TX_IE_LSB   = 24;
  localparam int RX_IE_LSB   = 16;
  localparam int TX_FLAG_LSB = 8;
  localparam int RX_OVR_BIT  = 3;
  localparam int RX_FLAG_LSB = 0;
  localparam logic [2:0] TX_IE_RST = 3'h0;
  localparam logic [3:0] RX_IE_RST = 4'h0;
endpackage

// ### logic/ctffi_core.sv
// Purpose: Time-stamp timer, filter control and FIFO status/enables
// Assumes: All inputs come from logic on clk_sys
// Notes:   Read data stand one cycle after the read strobe
// Function
// R01 - 16-bit stamp counter in timer bits 31:16 advances per divider period
// R02 - Divider field 15:0; zero advances every clock, all ones every 65535
// R03 - Capture enable low freezes counter and prescaler count
// R04 - Any timer write clears the prescaler count, divider kept as written
// R05 - Each filter enable bit: one takes part, zero ignored
// R06 - Two-bit mask choice selects acceptance mask 0 to 3
// R07 - Five-bit destination names FIFO 0 to 31 for matches
// R08 - Four filters per word, byte: enable 7, mask 6-5, dest 4-0
// R09 - Mask and destination writable only while filter disabled
// R10 - Transmit enables at bits 26, 25, 24, reset zero
// R11 - Receive enables at bits 19, 18, 17, 16, reset zero
// R12 - Status bits 10-8 and 2-0 read-only live; overflow bit 3 writable
// R13 - Not-full flag reads one with space in transmit mode, else zero
// R14 - Overflow flags gathered into a 32-bit read-only summary
// R15 - FIFO interrupt when any flag and its enable are both one
// R16 - Overflow set on arrival to a full FIFO, held until written zero
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ctffi_core (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Register port
  input  wire logic [9:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // CAN unit side
  input  wire logic        capture_enable,
  input  wire logic [31:0] queue_direction,
  input  wire logic [31:0] fifo_full,
  input  wire logic [31:0] fifo_half,
  input  wire logic [31:0] fifo_empty,
  input  wire logic [15:0] match_hit,
  output logic             accept_valid,
  output logic      [4:0]  accept_queue,
  output logic      [15:0] stamp_counter,
  output logic      [15:0] filter_on,
  output logic      [31:0] mask_choice,
  output logic      [79:0] dest_queue,
  output logic      [31:0] overrun_summary,
  output logic      [31:0] fifo_irq
);
  logic [15:0] stamp_divider;
  logic [15:0] pre_count;
  logic [15:0] next_counter;
  logic [15:0] next_divider;
  logic [15:0] next_pre;
  logic        wr_timer;
  logic        tick;
  logic [7:0]  flt      [ctffi_pkg::NFLT];
  logic [7:0]  next_flt [ctffi_pkg::NFLT];
  logic        wr_flt;
  logic [2:0]  tx_ie      [ctffi_pkg::NFIFO];
  logic [3:0]  rx_ie      [ctffi_pkg::NFIFO];
  logic [2:0]  next_tx_ie [ctffi_pkg::NFIFO];
  logic [3:0]  next_rx_ie [ctffi_pkg::NFIFO];
  logic [31:0] status     [ctffi_pkg::NFIFO];
  logic [31:0] ovr;
  logic [31:0] next_ovr;
  logic [31:0] set_ovr;
  logic [31:0] wr_fifo;
  logic [31:0] irq_now;
  logic [31:0] next_rdata;
  logic        hit_any;
  logic [4:0]  hit_queue;

  assign wr_timer = reg_wr && reg_addr == ctffi_pkg::OFS_TIMER;
  assign wr_flt   = reg_wr && reg_addr[9:4] == ctffi_pkg::OFS_FLT_BASE[9:4];
  // Divider zero behaves as one: a tick every clock
  assign tick = ({1'b0, pre_count} + 17'h00001) >= {1'b0, stamp_divider}; // [R02]

  // Time-stamp timer
  always_comb begin
    next_counter = stamp_counter;
    next_divider = stamp_divider;
    next_pre     = pre_count;
    if (wr_timer) begin
      next_counter = reg_wdata[ctffi_pkg::TS_LSB +: 16];
      next_divider = reg_wdata[ctffi_pkg::DIV_LSB +: 16];
      next_pre     = 16'h0000; // [R04]
    end else if (capture_enable) begin // [R03]
      if (tick) begin
        next_pre     = 16'h0000;
        next_counter = stamp_counter + 16'h0001; // [R01]
      end else begin
        next_pre = pre_count + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stamp_counter <= ctffi_pkg::TIMER_RST[ctffi_pkg::TS_LSB +: 16];
      stamp_divider <= ctffi_pkg::TIMER_RST[ctffi_pkg::DIV_LSB +: 16];
      pre_count     <= 16'h0000;
    end else begin
      stamp_counter <= next_counter;
      stamp_divider <= next_divider;
      pre_count     <= next_pre;
    end
  end

  // Filter control bytes
  always_comb begin
    for (int i = 0; i < ctffi_pkg::NFLT; i++) begin
      next_flt[i] = flt[i];
      if (wr_flt && reg_addr[3:2] == 2'(i / 4)) begin // [R08]
        if (!flt[i][ctffi_pkg::FLT_EN_BIT]) begin
          next_flt[i] = reg_wdata[8 * (i % 4) +: 8];
        end else begin
          // Enabled filter: only the enable itself may change
          next_flt[i][ctffi_pkg::FLT_EN_BIT] =
            reg_wdata[8 * (i % 4) + ctffi_pkg::FLT_EN_BIT]; // [R09]
        end
      end
    end
  end

  // Lowest numbered enabled filter wins when several match
  always_comb begin
    hit_any   = 1'b0;
    hit_queue = 5'h00;
    for (int i = ctffi_pkg::NFLT - 1; i >= 0; i--) begin
      if (match_hit[i] && flt[i][ctffi_pkg::FLT_EN_BIT]) begin // [R05]
        hit_any   = 1'b1;
        hit_queue = flt[i][ctffi_pkg::FLT_DST_LSB +: 5]; // [R07]
      end
    end
  end

  // Per-filter outputs and per-FIFO status
  genvar g;
  generate
    for (g = 0; g < ctffi_pkg::NFLT; g++) begin : g_flt
      assign filter_on[g]          = flt[g][ctffi_pkg::FLT_EN_BIT];
      assign mask_choice[2*g +: 2] = flt[g][ctffi_pkg::FLT_MSK_LSB +: 2]; // [R06]
      assign dest_queue[5*g +: 5]  = flt[g][ctffi_pkg::FLT_DST_LSB +: 5];
    end
    for (g = 0; g < ctffi_pkg::NFIFO; g++) begin : g_fifo
      logic       dir_tx;
      logic [2:0] tx_flag;
      logic [2:0] rx_flag;
      assign dir_tx = queue_direction[g];
      // Live fill state; flags of the other direction read zero
      assign tx_flag = {dir_tx & ~fifo_full[g], // [R13]
                        dir_tx & fifo_half[g],
                        dir_tx & fifo_empty[g]}; // [R12]
      assign rx_flag = {~dir_tx & fifo_full[g],
                        ~dir_tx & fifo_half[g],
                        ~dir_tx & ~fifo_empty[g]}; // [R12]
      assign wr_fifo[g] = reg_wr
                          && reg_addr[9:7] == ctffi_pkg::OFS_FIFO_BASE[9:7]
                          && reg_addr[6:2] == 5'(g);
      assign set_ovr[g] = hit_any && hit_queue == 5'(g)
                          && !dir_tx && fifo_full[g]; // [R16]
      assign status[g] = {5'h00, tx_ie[g], 4'h0, rx_ie[g], 5'h00,
                          tx_flag, 4'h0, ovr[g], rx_flag};
      assign irq_now[g] = |(tx_ie[g] & tx_flag)
                          | |(rx_ie[g] & {ovr[g], rx_flag}); // [R15]
    end
  endgenerate

  // FIFO enables and overflow flags
  always_comb begin
    for (int i = 0; i < ctffi_pkg::NFIFO; i++) begin
      next_tx_ie[i] = tx_ie[i];
      next_rx_ie[i] = rx_ie[i];
      next_ovr[i]   = ovr[i];
      if (wr_fifo[i]) begin
        next_tx_ie[i] = reg_wdata[ctffi_pkg::TX_IE_LSB +: 3]; // [R10]
        next_rx_ie[i] = reg_wdata[ctffi_pkg::RX_IE_LSB +: 4]; // [R11]
        // Writing one leaves the flag alone
        if (!reg_wdata[ctffi_pkg::RX_OVR_BIT]) begin
          next_ovr[i] = 1'b0; // [R16]
        end
      end
      // A new overrun beats a clear in the same cycle
      if (set_ovr[i]) begin
        next_ovr[i] = 1'b1; // [R16]
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < ctffi_pkg::NFLT; i++) begin
        flt[i] <= ctffi_pkg::FLT_RST;
      end
      for (int i = 0; i < ctffi_pkg::NFIFO; i++) begin
        tx_ie[i] <= ctffi_pkg::TX_IE_RST;
        rx_ie[i] <= ctffi_pkg::RX_IE_RST;
      end
      ovr          <= 32'h0000_0000;
      fifo_irq     <= 32'h0000_0000;
      accept_valid <= 1'b0;
      accept_queue <= 5'h00;
    end else begin
      flt          <= next_flt;
      tx_ie        <= next_tx_ie;
      rx_ie        <= next_rx_ie;
      ovr          <= next_ovr;
      fifo_irq     <= irq_now;
      accept_valid <= hit_any;
      accept_queue <= hit_queue;
    end
  end

  assign overrun_summary = ovr; // [R14]

  // Register read path
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == ctffi_pkg::OFS_TIMER) begin
        next_rdata = {stamp_counter, stamp_divider};
      end else if (reg_addr[9:4] == ctffi_pkg::OFS_FLT_BASE[9:4]) begin
        for (int b = 0; b < 4; b++) begin
          next_rdata[8*b +: 8] = flt[{reg_addr[3:2], 2'(b)}];
        end
      end else if (reg_addr == ctffi_pkg::OFS_OVF_SUM) begin
        next_rdata = ovr; // [R14]
      end else if (reg_addr[9:7] == ctffi_pkg::OFS_FIFO_BASE[9:7]) begin
        next_rdata = status[reg_addr[6:2]];
      end
    end
  end

  // Read data only valid the cycle after the strobe; zero otherwise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_stamp_hold: assert property ( // [R03]
    !capture_enable && !wr_timer |=>
      $stable(stamp_counter) && $stable(pre_count))
    else $error("stamp moved while capture off");

  chk_stamp_step: assert property ( // [R01]
    capture_enable && tick && !wr_timer |=>
      stamp_counter == $past(stamp_counter) + 16'h0001)
    else $error("stamp did not step on tick");

  chk_div_zero: assert property ( // [R02]
    capture_enable && stamp_divider == 16'h0000 && !wr_timer ##1
      capture_enable && !wr_timer |=>
      stamp_counter == $past(stamp_counter, 2) + 16'h0002)
    else $error("divider zero not every clock");

  chk_wr_clear: assert property ( // [R04]
    wr_timer |=> pre_count == 16'h0000
      && stamp_divider == $past(reg_wdata[15:0]))
    else $error("timer write did not clear prescaler");

  chk_flt_lock: assert property ( // [R09]
    wr_flt && reg_addr[3:2] == 2'h3 && filter_on[15] |=>
      $stable(dest_queue[79:75]) && $stable(mask_choice[31:30]))
    else $error("locked filter fields changed");

  chk_ovr_set: assert property ( // [R16]
    set_ovr[0] |=> overrun_summary[0] [*2] or
      (overrun_summary[0] ##1 1'b1))
    else $error("overflow not set on arrival");

  chk_ovr_hold: assert property ( // [R16]
    overrun_summary[0] && !(wr_fifo[0] && !reg_wdata[3]) |=>
      overrun_summary[0])
    else $error("overflow flag lost");

  chk_tx_space: assert property ( // [R13]
    status[0][10] == (queue_direction[0] && !fifo_full[0]))
    else $error("not-full flag does not follow fill state");

  chk_irq_raise: assert property ( // [R15]
    |({status[0][26:24], status[0][19:16]} &
      {status[0][10:8], status[0][3:0]}) |=> fifo_irq[0])
    else $error("enabled flag raised no interrupt");

  chk_sum_read: assert property ( // [R14]
    reg_rd && reg_addr == ctffi_pkg::OFS_OVF_SUM |=>
      reg_rdata == $past(overrun_summary))
    else $error("summary read mismatch");

  cov_ovr: cover property (set_ovr[0] ##1 overrun_summary[0]);
  cov_tick: cover property (stamp_divider == 16'h0003 && tick);
  cov_lock: cover property (wr_flt && filter_on[0]);
  cov_irq: cover property ($rose(fifo_irq[0]));
endmodule
`default_nettype wire

// ### dv/ctffi_fill_model.sv
// Purpose: Far-side model of the FIFO fill state seen by the block
// Assumes: Bench requests fill per FIFO on clk_sys
// Notes:   Half is implied by full, so the three states stay coherent
`timescale 1ns/1ps
`default_nettype none
module ctffi_fill_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Requested fill
  input  wire logic [31:0] want_full,
  input  wire logic [31:0] want_half,
  // Fill state
  output logic      [31:0] fifo_full,
  output logic      [31:0] fifo_half,
  output logic      [31:0] fifo_empty
);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fifo_full  <= 32'h0000_0000;
      fifo_half  <= 32'h0000_0000;
      fifo_empty <= 32'hFFFF_FFFF;
    end else begin
      fifo_full  <= want_full;
      fifo_half  <= want_full | want_half;
      fifo_empty <= ~(want_full | want_half);
    end
  end
endmodule
`default_nettype wire

// ### dv/tb_ctffi_core.sv
// Purpose: Random self-checking bench for the stamp/filter/FIFO block
// Assumes: Read data one cycle after the read strobe
// Notes:   The all-ones divider alone costs some 65k cycles
`timescale 1ns/1ps
`default_nettype none
module tb_ctffi_core;
  logic        clk_sys = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic        cap = 1'h0, av;
  logic [9:0]  reg_addr = '0;
  logic [31:0] reg_wdata = '0, dir = '0, wf = '0, wh = '0, ovf = '0;
  logic [31:0] rdata, full, half, empty, ovs, irq, mch, rd, d, w;
  logic [79:0] dst;
  logic [15:0] hit = '0, stamp, fon, s, h;
  logic [15:0] dv [4] = '{16'h0000, 16'h0001, 16'h0000, 16'hFFFF};
  logic [4:0]  aq;
  logic [7:0]  flt [16] = '{default: 8'h00};
  logic [6:0]  ie [32] = '{default: 7'h00};
  int          num_errors = 0, n_compared = 0, q, k, p;

  ctffi_fill_model fill (.clk_sys(clk_sys), .rst(rst), .want_full(wf),
    .want_half(wh), .fifo_full(full), .fifo_half(half), .fifo_empty(empty));
  ctffi_core dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .capture_enable(cap), .queue_direction(dir),
    .fifo_full(full), .fifo_half(half), .fifo_empty(empty),
    .match_hit(hit), .accept_valid(av), .accept_queue(aq),
    .stamp_counter(stamp), .filter_on(fon), .mask_choice(mch),
    .dest_queue(dst), .overrun_summary(ovs), .fifo_irq(irq));

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  // Flags of the other direction read zero
  function automatic logic [31:0] fifo_word(int n);
    logic f, hf, t;
    f = wf[n];
    hf = wf[n] | wh[n];
    t = dir[n];
    return {5'h00, ie[n][6:4], 4'h0, ie[n][3:0], 5'h00, t & ~f, t & hf,
            t & ~hf, 4'h0, ovf[n], ~t & f, ~t & hf, ~t & hf};
  endfunction

  // Enable bits line up with their flags bit for bit
  function automatic logic irq_exp(int n);
    logic [31:0] x;
    x = fifo_word(n);
    return |({x[26:24], x[19:16]} & {x[10:8], x[3:0]});
  endfunction

  task automatic chk(input string nm, input logic [79:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask

  // Read data are taken at the edge that ends their only valid cycle
  task automatic rdr(input logic [9:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    @(posedge clk_sys);
    rd = rdata;
  endtask

  task automatic close_out();
    if (num_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    void'($urandom(42847));
    repeat (2) @(posedge clk_sys);
    rst <= 1'h0;
    for (int n = 0; n < 32; n++) begin
      rdr(ctffi_pkg::OFS_FIFO_BASE + 10'(4 * n));
      chk("fifo reg reset", rd, fifo_word(n));
    end
    rdr(10'h3FC);
    chk("unmapped", rd, 32'h0000_0000);
    dv[2] = 16'(2 + $urandom % 19);
    cap <= 1'h1;
    foreach (dv[i]) begin
      p = (dv[i] == 16'h0000) ? 1 : int'(dv[i]);
      s = 16'($urandom);
      wr(ctffi_pkg::OFS_TIMER, {s, dv[i]});
      repeat (p - 1) @(posedge clk_sys);
      #1 chk("stamp hold", stamp, s);
      @(posedge clk_sys);
      #1 chk("stamp step", stamp, 16'(s + 16'h0001));
    end
    @(posedge clk_sys);
    cap <= 1'h0;
    @(posedge clk_sys);
    s = stamp;
    repeat (30) @(posedge clk_sys);
    chk("frozen", stamp, s);
    rdr(ctffi_pkg::OFS_TIMER);
    chk("timer reg", rd, {s, 16'hFFFF});
    // Pause mid-period: the prescaler count must resume, not restart
    wr(ctffi_pkg::OFS_TIMER, {s, 16'h0003});
    cap <= 1'h1;
    @(posedge clk_sys);
    cap <= 1'h0;
    repeat (10) @(posedge clk_sys);
    cap <= 1'h1;
    @(posedge clk_sys);
    #1 chk("pause hold", stamp, s);
    @(posedge clk_sys);
    #1 chk("pause resume", stamp, 16'(s + 16'h0001));
    repeat (40) begin
      k = $urandom % 4;
      d = $urandom;
      wr(ctffi_pkg::OFS_FLT_BASE + 10'(4 * k), d);
      for (int b = 0; b < 4; b++) begin
        flt[4*k+b] = flt[4*k+b][7] ? {d[8*b+7], flt[4*k+b][6:0]}
                                   : d[8*b +: 8];
      end
      rdr(ctffi_pkg::OFS_FLT_BASE + 10'(4 * k));
      chk("flt word", rd, {flt[4*k+3], flt[4*k+2], flt[4*k+1],
                           flt[4*k]});
      for (int i = 0; i < 16; i++) begin
        chk("filter_on", fon[i], flt[i][7]);
        chk("mask_choice", mch[2*i +: 2], flt[i][6:5]);
        chk("dest_queue", dst[5*i +: 5], flt[i][4:0]);
      end
    end
    repeat (40) begin
      dir <= $urandom;
      wf <= $urandom;
      wh <= $urandom;
      h = 16'($urandom & $urandom);
      repeat (3) @(posedge clk_sys);
      hit <= h;
      @(posedge clk_sys);
      hit <= 16'h0000;
      q = -1;
      for (int i = 15; i >= 0; i--) begin
        if (h[i] && flt[i][7])
          q = i;
      end
      if (q >= 0 && !dir[flt[q][4:0]] && wf[flt[q][4:0]])
        ovf[flt[q][4:0]] = 1'h1;
      #1 chk("accept", av, q >= 0);
      if (q >= 0)
        chk("queue", aq, flt[q][4:0]);
      chk("overrun", ovs, ovf);
      rdr(ctffi_pkg::OFS_OVF_SUM);
      chk("summary read", rd, ovf);
      k = $urandom % 32;
      w = $urandom;
      wr(ctffi_pkg::OFS_FIFO_BASE + 10'(4 * k), w);
      ie[k] = {w[26:24], w[19:16]};
      if (!w[3])
        ovf[k] = 1'h0;
      rdr(ctffi_pkg::OFS_FIFO_BASE + 10'(4 * k));
      chk("fifo reg", rd, fifo_word(k));
      for (int n = 0; n < 32; n++) begin
        chk("irq", irq[n], irq_exp(n));
      end
    end
    // The summary is read-only: a write must leave it as it was
    wr(ctffi_pkg::OFS_OVF_SUM, ~ovf);
    rdr(ctffi_pkg::OFS_OVF_SUM);
    chk("summary ro", rd, ovf);
    close_out();
  end

  // About 66k cycles are expected; this leaves a wide margin
  initial begin
    repeat (100000) @(posedge clk_sys);
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire
